/* dwb_cfg.svh */
// Constants for the write-burst timing block
`ifndef DWB_CFG_SVH
`define DWB_CFG_SVH

// Burst-length field codes of mode_register_zero
`define DWB_BL_EIGHT 2'h0
`define DWB_BL_PER_COMMAND 2'h1
`define DWB_BL_FIXED_CHOP 2'h2

// Clocks from first data beat to the recovery reference edge
`define DWB_SLOT_CLOCKS 7'h04
`define DWB_FIXED_CHOP_CLOCKS 7'h02

// Pipeline stage plus output register ahead of every event
`define DWB_OUT_STAGES 7'h02

// Data-window hold counts after the first beat clock
`define DWB_EIGHT_HOLD 2'h3
`define DWB_CHOP_HOLD 2'h1

// Delay-line depth covers the largest latency sum plus the slots
`define DWB_PIPE_DEPTH 64
`define DWB_NUM_BANKS 16
`define DWB_BANK_W 4
`define DWB_WR_W 5

`endif

/* dwb_pkg.sv */
// Types shared by the write-burst timing modules
package dwb_pkg;

  typedef enum logic [2:0] {
    BURST_EIGHT = 3'h1,
    BURST_PER_COMMAND_CHOP = 3'h2,
    BURST_FIXED_CHOP = 3'h4
  } dwb_burst_type;

  typedef struct packed {
    logic valid;
    logic fixed;
    logic chop;
  } dwb_start_type;

  typedef struct packed {
    logic valid;
    logic auto_pre;
    logic [3:0] bank;
  } dwb_ref_type;

endpackage : dwb_pkg

/* dwb_ap_if.sv */
// Recovery reference hand-off between the burst timer and the auto-precharge timers
`timescale 1ns/100ps
`default_nettype none
interface dwb_ap_if;
  logic ref_valid;
  logic auto_pre;
  logic [3:0] bank;
  logic [4:0] wr_count;
  logic pre_pulse;
  logic [3:0] pre_bank;

  modport burst (
    output ref_valid,
    output auto_pre,
    output bank,
    output wr_count,
    input pre_pulse,
    input pre_bank
  );

  modport timer (
    input ref_valid,
    input auto_pre,
    input bank,
    input wr_count,
    output pre_pulse,
    output pre_bank
  );
endinterface : dwb_ap_if
`default_nettype wire

/* dwb_ap_timer.sv */
// Per-bank write recovery timers that launch the internal precharge after auto-precharge writes
`timescale 1ns/100ps
`default_nettype none
`include "dwb_cfg.svh"
module dwb_ap_timer #(
  parameter int NUM_BANKS = `DWB_NUM_BANKS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Reference and precharge hand-off
  dwb_ap_if.timer ap
);

  logic [4:0] cnt_q [NUM_BANKS];
  logic [NUM_BANKS-1:0] due;
  logic [NUM_BANKS-1:0] grant;
  logic pre_pulse_q;
  logic [3:0] pre_bank_q;
  logic [4:0] load_value;

  // Lowest-numbered due bank wins; others keep waiting at one
  function automatic logic [NUM_BANKS-1:0] lowest_one(input logic [NUM_BANKS-1:0] v);
    logic [NUM_BANKS-1:0] r;
    r = v & (~v + 1'b1);
    return r;
  endfunction : lowest_one

  function automatic logic [3:0] bank_index(input logic [NUM_BANKS-1:0] onehot);
    logic [3:0] idx;
    idx = 4'h0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (onehot[b]) begin
        idx = 4'(b);
      end
    end
    return idx;
  endfunction : bank_index

  // Counter lands on one at the clock before the precharge edge
  assign load_value = ap.wr_count - 5'h01;
  assign grant = lowest_one(due);
  assign ap.pre_pulse = pre_pulse_q;
  assign ap.pre_bank = pre_bank_q;

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic load;
    assign due[b] = (cnt_q[b] == 5'h01);
    assign load = ap.ref_valid && ap.auto_pre && (ap.bank == 4'(b));
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        cnt_q[b] <= 5'h00;
      end else if (load) begin
        cnt_q[b] <= load_value;
      end else if (cnt_q[b] > 5'h01 || grant[b]) begin
        cnt_q[b] <= cnt_q[b] - 5'h01;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_pulse_q <= 1'b0;
      pre_bank_q <= 4'h0;
    end else begin
      pre_pulse_q <= |due;
      pre_bank_q <= bank_index(grant);
    end
  end

endmodule : dwb_ap_timer
`default_nettype wire

/* dwb_write_timing.sv */
// Write-burst length selection, data window and recovery reference timing inside the memory device
`timescale 1ns/100ps
`default_nettype none
`include "dwb_cfg.svh"
module dwb_write_timing #(
  parameter int PIPE_DEPTH = `DWB_PIPE_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Write command from the controller
  input wire logic i_wr_cmd,
  input wire logic i_wr_auto_pre,
  input wire logic i_chop_select_bit,
  input wire logic [1:0] i_bank_group,
  input wire logic [1:0] i_bank,
  // Mode settings
  input wire logic [1:0] i_burst_len_field,
  input wire logic [4:0] i_additive_latency,
  input wire logic [4:0] i_write_latency,
  input wire logic i_parity_en,
  input wire logic [2:0] i_parity_latency,
  input wire logic [4:0] i_write_recovery,
  // Burst timing outputs
  output logic o_data_window,
  output logic o_burst_chop,
  output logic o_burst_fixed,
  output logic o_recovery_ref,
  // Internal precharge
  output logic o_int_precharge,
  output logic [3:0] o_int_precharge_bank
);

  localparam int IW = $clog2(PIPE_DEPTH);

  dwb_pkg::dwb_start_type start_pipe_q [PIPE_DEPTH];
  dwb_pkg::dwb_ref_type ref_pipe_q [PIPE_DEPTH];
  dwb_pkg::dwb_burst_type wr_kind;
  dwb_pkg::dwb_start_type new_start;
  dwb_pkg::dwb_ref_type new_ref;
  logic wr_chop;
  logic wr_fixed;
  logic [2:0] parity_add;
  logic [6:0] lat_base;
  logic [6:0] ref_offset;
  logic [IW-1:0] start_idx;
  logic [IW-1:0] ref_idx;
  logic [1:0] beat_cnt_q;
  logic data_window_q;
  logic burst_chop_q;
  logic burst_fixed_q;
  logic recovery_ref_q;
  logic ref_ap_q;
  logic [3:0] ref_bank_q;

  dwb_ap_if ap_if ();

  function automatic dwb_pkg::dwb_burst_type burst_kind(input logic [1:0] field, input logic chop_bit);
    dwb_pkg::dwb_burst_type k;
    k = dwb_pkg::BURST_EIGHT;
    // The reserved code 11 falls back to eight beats
    case (field)
      `DWB_BL_EIGHT: k = dwb_pkg::BURST_EIGHT;
      `DWB_BL_PER_COMMAND: k = chop_bit ? dwb_pkg::BURST_EIGHT : dwb_pkg::BURST_PER_COMMAND_CHOP;
      `DWB_BL_FIXED_CHOP: k = dwb_pkg::BURST_FIXED_CHOP;
      default: k = dwb_pkg::BURST_EIGHT;
    endcase
    return k;
  endfunction : burst_kind

  // Length decided from the chop bit sampled with this very command
  assign wr_kind = burst_kind(i_burst_len_field, i_chop_select_bit);
  assign wr_chop = (wr_kind != dwb_pkg::BURST_EIGHT);
  assign wr_fixed = (wr_kind == dwb_pkg::BURST_FIXED_CHOP);

  // Parity latency shifts both the data and the reference edge
  assign parity_add = i_parity_en ? i_parity_latency : 3'h0;
  assign lat_base = {2'h0, i_additive_latency} + {2'h0, i_write_latency} + {4'h0, parity_add};
  // Per-command chop still owns four bus slots; only fixed chop frees them
  assign ref_offset = wr_fixed ? `DWB_FIXED_CHOP_CLOCKS : `DWB_SLOT_CLOCKS;
  assign start_idx = IW'(lat_base - `DWB_OUT_STAGES);
  assign ref_idx = IW'(lat_base + ref_offset - `DWB_OUT_STAGES);

  assign new_start = '{valid: 1'b1, fixed: wr_fixed, chop: wr_chop};
  assign new_ref = '{valid: 1'b1, auto_pre: i_wr_auto_pre, bank: {i_bank_group, i_bank}};

  // Delay lines: each entry walks toward slot zero one clock at a time
  for (genvar i = 0; i < PIPE_DEPTH; i++) begin : g_pipe
    dwb_pkg::dwb_start_type start_next;
    dwb_pkg::dwb_ref_type ref_next;
    logic start_ins;
    logic ref_ins;
    if (i == PIPE_DEPTH - 1) begin : g_last
      assign start_next = '0;
      assign ref_next = '0;
    end else begin : g_mid
      assign start_next = start_pipe_q[i+1];
      assign ref_next = ref_pipe_q[i+1];
    end
    assign start_ins = i_wr_cmd && (start_idx == IW'(i));
    assign ref_ins = i_wr_cmd && (ref_idx == IW'(i));
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        start_pipe_q[i] <= '0;
        ref_pipe_q[i] <= '0;
      end else begin
        start_pipe_q[i] <= start_ins ? new_start : start_next;
        ref_pipe_q[i] <= ref_ins ? new_ref : ref_next;
      end
    end
  end

  // Data window: four clocks for eight beats, two for a chopped burst
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      beat_cnt_q <= 2'h0;
      data_window_q <= 1'b0;
      burst_chop_q <= 1'b0;
      burst_fixed_q <= 1'b0;
    end else if (start_pipe_q[0].valid) begin
      beat_cnt_q <= start_pipe_q[0].chop ? `DWB_CHOP_HOLD : `DWB_EIGHT_HOLD;
      data_window_q <= 1'b1;
      burst_chop_q <= start_pipe_q[0].chop;
      burst_fixed_q <= start_pipe_q[0].fixed;
    end else begin
      beat_cnt_q <= (beat_cnt_q != 2'h0) ? beat_cnt_q - 2'h1 : 2'h0;
      data_window_q <= (beat_cnt_q != 2'h0);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      recovery_ref_q <= 1'b0;
      ref_ap_q <= 1'b0;
      ref_bank_q <= 4'h0;
    end else begin
      recovery_ref_q <= ref_pipe_q[0].valid;
      ref_ap_q <= ref_pipe_q[0].auto_pre;
      ref_bank_q <= ref_pipe_q[0].bank;
    end
  end

  assign ap_if.ref_valid = recovery_ref_q;
  assign ap_if.auto_pre = ref_ap_q;
  assign ap_if.bank = ref_bank_q;
  assign ap_if.wr_count = i_write_recovery;

  dwb_ap_timer #(
    .NUM_BANKS(`DWB_NUM_BANKS)
  ) u_ap_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .ap(ap_if.timer)
  );

  assign o_data_window = data_window_q;
  assign o_burst_chop = burst_chop_q;
  assign o_burst_fixed = burst_fixed_q;
  assign o_recovery_ref = recovery_ref_q;
  assign o_int_precharge = ap_if.pre_pulse;
  assign o_int_precharge_bank = ap_if.pre_bank;

  // Plain setting: no additive or parity latency, write latency nine
  logic base_cfg;
  assign base_cfg = (i_additive_latency == 5'h00) && (i_write_latency == 5'h09) && !i_parity_en;

  a_eight_beat_len: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && base_cfg && (i_burst_len_field == 2'h0)
    |-> ##9 (o_data_window && !o_burst_chop) [*4] ##1 o_recovery_ref)
    else $error("eight-beat write window or reference misplaced");

  a_otf_chop_len: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && base_cfg && (i_burst_len_field == 2'h1) && !i_chop_select_bit
    |-> ##9 (o_data_window && o_burst_chop && !o_burst_fixed) ##4 o_recovery_ref)
    else $error("per-command chop write misplaced");

  a_fixed_chop_len: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && base_cfg && (i_burst_len_field == 2'h2)
    |-> ##9 (o_data_window && o_burst_chop && o_burst_fixed) ##1 o_data_window ##1 o_recovery_ref)
    else $error("fixed chop write misplaced");

  a_per_cmd_chop: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && base_cfg && (i_burst_len_field == 2'h1)
    |-> ##9 (o_burst_chop != $past(i_chop_select_bit, 9)))
    else $error("burst length not taken from its own command");

  a_fixed_ref_early: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_data_window) && o_burst_fixed |-> ##2 o_recovery_ref)
    else $error("fixed chop reference not two clocks after first beat");

  a_parity_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && (i_additive_latency == 5'h00) && (i_write_latency == 5'h09) && i_parity_en
    && (i_parity_latency == 3'h4) && (i_burst_len_field == 2'h0)
    |-> ##13 o_data_window ##4 o_recovery_ref)
    else $error("parity latency not applied to write timing");

  a_auto_pre_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr_cmd && i_wr_auto_pre && base_cfg && (i_burst_len_field == 2'h0) && (i_write_recovery == 5'h0C)
    |-> ##13 o_recovery_ref ##12 (o_int_precharge && o_int_precharge_bank == $past({i_bank_group, i_bank}, 25)))
    else $error("internal precharge not at recovery count after reference");

endmodule : dwb_write_timing
`default_nettype wire

/* dwb_mc_model.sv */
// Memory controller model that issues write commands to the device
`timescale 1ns/100ps
`default_nettype none
module dwb_mc_model #(
  // Arbitrary defaults: the block itself does not time these gaps
  parameter int SHORT_WTR = 2,
  parameter int LONG_WTR = 6,
  parameter int INV_EXTRA = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Device feedback
  input wire logic i_recovery_ref,
  input wire logic [4:0] i_write_recovery,
  input wire logic i_inversion_en,
  // Write command
  output logic o_wr_cmd,
  output logic o_wr_auto_pre,
  output logic o_chop_select_bit,
  output logic [3:0] o_bank_id,
  // Precharge to the written bank allowed
  output logic o_pre_ok,
  // Read to another or to the same bank group allowed
  output logic o_rd_ok_other,
  output logic o_rd_ok_same
);
  logic [5:0] rec_q;
  logic [4:0] wtr_s_q;
  logic [4:0] wtr_l_q;
  logic [4:0] extra;
  initial begin
    o_wr_cmd = 1'h0;
    o_wr_auto_pre = 1'h0;
    o_chop_select_bit = 1'h0;
    o_bank_id = 4'h0;
  end
  // Counting starts at the reference edge, so a precharge waits out the full recovery
  // Inversion lengthens both recovery and write-to-read gaps
  assign extra = i_inversion_en ? 5'(INV_EXTRA) : 5'h00;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      rec_q <= 6'h00;
    else if (i_recovery_ref)
      rec_q <= {1'b0, i_write_recovery} + {1'b0, extra};
    else if (rec_q != 6'h00)
      rec_q <= rec_q - 6'h01;
  end
  assign o_pre_ok = rec_q == 6'h00;
  // Same bank group waits the long gap, another group the short one
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wtr_s_q <= 5'h00;
      wtr_l_q <= 5'h00;
    end else if (i_recovery_ref) begin
      wtr_s_q <= 5'(SHORT_WTR) + extra;
      wtr_l_q <= 5'(LONG_WTR) + extra;
    end else begin
      wtr_s_q <= (wtr_s_q != 5'h00) ? wtr_s_q - 5'h01 : 5'h00;
      wtr_l_q <= (wtr_l_q != 5'h00) ? wtr_l_q - 5'h01 : 5'h00;
    end
  end
  assign o_rd_ok_other = wtr_s_q == 5'h00;
  assign o_rd_ok_same = wtr_l_q == 5'h00;
  // One command per call; qualifiers are inverted afterwards so stale values never look valid
  task automatic issue(input logic a, input logic c, input logic [3:0] b);
    @(posedge i_clk);
    o_wr_cmd <= 1'h1;
    o_wr_auto_pre <= a;
    o_chop_select_bit <= c;
    o_bank_id <= b;
    @(posedge i_clk);
    o_wr_cmd <= 1'h0;
    o_wr_auto_pre <= ~a;
    o_chop_select_bit <= ~c;
    o_bank_id <= ~b;
  endtask : issue
endmodule : dwb_mc_model
`default_nettype wire

/* tb_dwb_write_timing.sv */
// Self-checking bench for the write-burst timing block
`timescale 1ns/100ps
`default_nettype none
module tb_dwb_write_timing;
  typedef struct {int tw; int tr; logic c; logic f;} dwb_exp_type;
  typedef struct {int t; logic [3:0] b;} dwb_pre_type;
  logic i_clk, i_rst, wr, ap, cb, pen, win, chop, fixd, rref, ipre;
  logic inv, pok, rdo, rds;
  logic [3:0] bid, ipb;
  logic [1:0] fld;
  logic [4:0] al, write_latency, wrc;
  logic [2:0] pl;
  logic [31:0] rs = 32'h10;
  logic [31:0] r;
  int cyc = 0;
  int seen = 0;
  int nwin = 0;
  int miscompares = 0;
  int checked = 0;
  dwb_exp_type eq[$];
  dwb_pre_type pq[$];

  dwb_mc_model mc (.i_clk(i_clk), .i_rst(i_rst), .i_recovery_ref(rref), .i_write_recovery(wrc),
    .i_inversion_en(inv), .o_wr_cmd(wr), .o_wr_auto_pre(ap), .o_chop_select_bit(cb), .o_bank_id(bid),
    .o_pre_ok(pok), .o_rd_ok_other(rdo), .o_rd_ok_same(rds));
  dwb_write_timing #(.PIPE_DEPTH(64)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr_cmd(wr),
    .i_wr_auto_pre(ap), .i_chop_select_bit(cb), .i_bank_group(bid[3:2]), .i_bank(bid[1:0]),
    .i_burst_len_field(fld), .i_additive_latency(al), .i_write_latency(write_latency), .i_parity_en(pen),
    .i_parity_latency(pl), .i_write_recovery(wrc), .o_data_window(win), .o_burst_chop(chop),
    .o_burst_fixed(fixd), .o_recovery_ref(rref), .o_int_precharge(ipre), .o_int_precharge_bank(ipb));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      $display("[ERR] %0t %s", $time, m);
      miscompares++;
    end
  endtask : chk

  task automatic conclude();
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Expectations are noted at the edge that takes the command (T0)
  task automatic wr_note(input logic a, input logic c, input logic [3:0] b, input int gap);
    int t;
    logic ch, fx;
    repeat (gap) @(posedge i_clk);
    mc.issue(a, c, b);
    t = cyc + int'(al) + int'(write_latency) + (pen ? int'(pl) : 0);
    fx = fld == 2'h2;
    ch = fx || (fld == 2'h1 && !c);
    eq.push_back('{t, t + (fx ? 2 : 4), ch, fx});
    nwin += ch ? 2 : 4;
    if (a)
      pq.push_back('{t + (fx ? 2 : 4) + int'(wrc), b});
  endtask : wr_note

  task automatic drain();
    int n;
    n = 0;
    while ((eq.size() > 0 || pq.size() > 0) && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk(n < 200, "pending events never came");
    repeat (2) @(posedge i_clk);
  endtask : drain

  // Watcher: every pulse takes the oldest note and compares
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (win === 1'b1)
      seen++;
    if (rref === 1'b1) begin
      chk(eq.size() > 0 && cyc == eq[0].tr, "reference edge misplaced");
      if (eq.size() > 0)
        void'(eq.pop_front());
    end else if (eq.size() > 0 && cyc > eq[0].tr) begin
      chk(1'b0, "reference edge missing");
      void'(eq.pop_front());
    end
    // Any pending write may start its window, not only the oldest one
    foreach (eq[j])
      if (cyc == eq[j].tw)
        chk(win === 1'b1 && chop === eq[j].c && fixd === eq[j].f, "burst start or kind wrong");
    if (ipre === 1'b1) begin
      chk(pq.size() > 0 && cyc == pq[0].t && ipb === pq[0].b, "internal precharge wrong");
      if (pq.size() > 0)
        void'(pq.pop_front());
    end else if (pq.size() > 0 && cyc > pq[0].t) begin
      chk(1'b0, "internal precharge missing");
      void'(pq.pop_front());
    end
  end

  initial begin
    #(20000 * 4);
    $display("[ERR] %0t run did not finish", $time);
    miscompares++;
    conclude();
  end

  initial begin
    i_rst = 1'b1;
    fld = 2'h0;
    al = 5'h00;
    write_latency = 5'h09;
    pen = 1'b0;
    pl = 3'h4;
    wrc = 5'h0C;
    inv = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    chk(win === 1'b0 && rref === 1'b0 && ipre === 1'b0 && chop === 1'b0, "outputs not idle in reset");
    // Every field code, back-to-back or one clock apart, mixed lengths and random auto-precharge
    for (int m = 0; m < 4; m++) begin
      fld <= 2'(m);
      @(posedge i_clk);
      for (int i = 0; i < 4; i++) begin
        r = xs();
        wr_note(r[0], r[1], 4'(i * 5), 2 + int'(r[3:2] == 2'h0));
      end
      drain();
    end
    // Parity latency 4 with writes at T0 and T4
    pen <= 1'b1;
    fld <= 2'h0;
    @(posedge i_clk);
    wr_note(1'b0, 1'b1, 4'h3, 0);
    wr_note(1'b0, 1'b1, 4'h4, 2);
    drain();
    // Write CRC spacing: five clocks apart, eight beats then a chopped burst
    pen <= 1'b0;
    fld <= 2'h1;
    @(posedge i_clk);
    wr_note(1'b1, 1'b1, 4'h6, 0);
    wr_note(1'b1, 1'b0, 4'h9, 3);
    drain();
    // Random latencies and recovery counts
    for (int k = 0; k < 8; k++) begin
      r = xs();
      fld <= r[1:0];
      pen <= r[2];
      al <= {2'h0, r[5:3]};
      write_latency <= 5'h09 + {3'h0, r[7:6]};
      wrc <= 5'h02 + 5'(r[12:8] % 5'd30);
      inv <= r[13];
      @(posedge i_clk);
      for (int i = 0; i < 3; i++) begin
        r = xs();
        wr_note(r[0], r[1], 4'(k + i * 4), 2 + int'(r[2]));
      end
      drain();
    end
    chk(seen == nwin, "data window length wrong");
    repeat (40) @(posedge i_clk);
    chk(pok === 1'b1 && rdo === 1'b1 && rds === 1'b1, "controller gates never released");
    conclude();
  end
endmodule : tb_dwb_write_timing
`default_nettype wire
